// File: rtl/crf_pkg.sv
//------------------------------------------------------------------------------
// Constants and types of the banked CPU register set
//------------------------------------------------------------------------------
// Holds selector codes, access modes, bus offsets and reset values.
// Assumes one 50 MHz core clock and a synchronous active-low reset.
//
// Summary of operation
// RULE_01: Thirteen registers, seven of them banked twice
// RULE_02: Four 16-bit data registers for operands
// RULE_03: First two data registers split into bytes
// RULE_04: Pairs acc2:acc0 and acc3:acc1 form 32 bits
// RULE_05: Two 16-bit index registers, also address operands
// RULE_06: index_reg_1:index_reg_0 forms one 32-bit pair
// RULE_07: 16-bit frame base for frame-relative addressing
// RULE_08: 20-bit program counter holds next instruction
// RULE_09: 20-bit vector table base register
// RULE_10: Separate 16-bit user and interrupt stack pointers
// RULE_11: Flag bit 7 picks the active stack pointer
// RULE_12: Flag clear selects interrupt pointer, set user
// RULE_13: Interrupt acknowledge clears stack select flag
// RULE_14: Flag bit 4 selects register bank
// RULE_15: 16-bit static base register held once
// RULE_16: Unbanked registers ignore the bank select
// RULE_17: Writes on clock edge, only covered bits
package crf_pkg;

  //----------------------------------------------------------------------------
  // Selectors and modes
  //----------------------------------------------------------------------------
  // Banked entries come first so their code is the index within a bank
  typedef enum logic [3:0] {
    SEL_ACC0, SEL_ACC1, SEL_ACC2, SEL_ACC3, SEL_IDX0, SEL_IDX1, SEL_FB,
    SEL_SB, SEL_USP, SEL_ISP, SEL_SP, SEL_VECTOR_TABLE_BASE, SEL_FLG, SEL_PC
  } crf_sel_t;

  typedef enum logic [1:0] {
    MODE_WORD, MODE_LOW, MODE_HIGH, MODE_PAIR
  } crf_mode_t;

  localparam int BANK_REGS = 7;            // Banked registers per bank
  localparam int BANKED_TOTAL = 14;        // Both banks together
  localparam int FLG_BANK_BIT = 4;         // Bank select flag position
  localparam int FLG_STACK_BIT = 7;        // Stack select flag position
  localparam logic [15:0] FLG_MASK = 16'h70ff;  // Implemented flag bits

  //----------------------------------------------------------------------------
  // Reset values
  //----------------------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [19:0] RST_PC = 20'h00000;
  localparam logic [19:0] RST_VECTOR_TABLE_BASE = 20'h00000;
  localparam logic [15:0] RST_FLG = 16'h0000;   // Bank 0, interrupt stack

  //----------------------------------------------------------------------------
  // Bus word indices (byte address = index * 4)
  //----------------------------------------------------------------------------
  localparam logic [4:0] IDX_BANK1 = 5'h08;   // Bank 1 copies start here
  localparam logic [4:0] IDX_PC = 5'h10;
  localparam logic [4:0] IDX_VECTOR_TABLE_BASE = 5'h11;
  localparam logic [4:0] IDX_USP = 5'h12;
  localparam logic [4:0] IDX_ISP = 5'h13;
  localparam logic [4:0] IDX_SB = 5'h14;
  localparam logic [4:0] IDX_FLG = 5'h15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : crf_pkg

// File: rtl/crf_cpu_regs.sv
//------------------------------------------------------------------------------
// Banked CPU register set with AXI4-Lite debug access
//------------------------------------------------------------------------------
// Core datapath reads and writes on clock_in; software sees every register
// over AXI4-Lite. Core writes take priority over bus writes.
`timescale 1ns/1ps

module crf_cpu_regs
  import crf_pkg::*;
(
  input wire logic clock_in,              // Core clock, 50 MHz
  input wire logic rst_n_in,              // Sync reset, active low
  input wire logic wr_en_in,              // Core write strobe
  input wire logic [3:0] wr_sel_in,       // Core write target
  input wire logic [1:0] wr_mode_in,      // Word, byte or pair
  input wire logic [31:0] wr_data_in,     // Core write data
  input wire logic [3:0] rd_sel_in,       // Core read source
  input wire logic [1:0] rd_mode_in,      // Word, byte or pair
  output logic [31:0] rd_data_out,        // Read data, next cycle
  input wire logic pc_load_in,            // Load program counter
  input wire logic [19:0] pc_data_in,     // Next instruction address
  input wire logic irq_ack_in,            // Hardware interrupt taken
  output logic [19:0] pc_out,             // Program counter
  output logic [19:0] vector_table_base_out,           // Vector table base
  output logic [15:0] sp_out,             // Active stack pointer
  output logic [15:0] fb_out,             // Frame base, active bank
  output logic [15:0] sb_out,             // Static base
  output logic [15:0] idx0_out,           // Index register 0, active bank
  output logic [15:0] idx1_out,           // Index register 1, active bank
  output logic [15:0] flag_out,           // Flag word
  input wire logic [6:0] s_axi_awaddr,    // Write address
  input wire logic s_axi_awvalid,         // Write address valid
  output logic s_axi_awready,             // Write address ready
  input wire logic [31:0] s_axi_wdata,    // Write data
  input wire logic [3:0] s_axi_wstrb,     // Write byte strobes
  input wire logic s_axi_wvalid,          // Write data valid
  output logic s_axi_wready,              // Write data ready
  output logic [1:0] s_axi_bresp,         // Write response
  output logic s_axi_bvalid,              // Write response valid
  input wire logic s_axi_bready,          // Write response ready
  input wire logic [6:0] s_axi_araddr,    // Read address
  input wire logic s_axi_arvalid,         // Read address valid
  output logic s_axi_arready,             // Read address ready
  output logic [31:0] s_axi_rdata,        // Read data
  output logic [1:0] s_axi_rresp,         // Read response
  output logic s_axi_rvalid,              // Read data valid
  input wire logic s_axi_rready           // Read data ready
);

  //----------------------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------------------
  logic [15:0] bank_r [BANKED_TOTAL];  // Bank 0 at 0..6, bank 1 at 7..13
  logic [19:0] pc_r;                   // Program counter
  logic [19:0] vector_table_base_r;                 // Vector table base
  logic [15:0] usp_r;                  // User stack pointer
  logic [15:0] isp_r;                  // Interrupt stack pointer
  logic [15:0] sb_r;                   // Static base
  logic [15:0] flag_r;                 // Flag word
  logic [31:0] rd_data_r;              // Core read data
  logic aw_held_r, w_held_r;           // Bus write halves captured
  logic [4:0] aw_idx_r;                // Captured write word index
  logic [31:0] w_data_r;               // Captured write data
  logic [3:0] w_strb_r;                // Captured strobes
  logic bvalid_r, rvalid_r;            // Bus answers pending
  logic [1:0] bresp_r, rresp_r;        // Bus answer codes
  logic [31:0] rdata_r;                // Bus read data

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------
  // Upper partner of a 32-bit pair, 4'hf when the code has none
  function automatic logic [3:0] pair_hi(input logic [3:0] sel);
    unique case (sel)
      SEL_ACC0: pair_hi = SEL_ACC2;  // RULE_04
      SEL_ACC1: pair_hi = SEL_ACC3;  // RULE_04
      SEL_IDX0: pair_hi = SEL_IDX1;  // RULE_06
      default: pair_hi = 4'hf;
    endcase
  endfunction : pair_hi

  // Merge new data into a 16-bit register under a write mode
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [1:0] mode);
    unique case (mode)
      MODE_LOW: merge16 = {old[15:8], data[7:0]};   // RULE_03
      MODE_HIGH: merge16 = {data[7:0], old[7:0]};   // RULE_03
      default: merge16 = data[15:0];
    endcase
  endfunction : merge16

  // Byte-strobe merge for bus writes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      strb_merge[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : strb_merge

  //----------------------------------------------------------------------------
  // Selection
  //----------------------------------------------------------------------------
  wire logic bank_sel = flag_r[FLG_BANK_BIT];              // RULE_14
  wire logic user_sp = flag_r[FLG_STACK_BIT];              // RULE_11
  wire logic [3:0] act_base = bank_sel ? 4'd7 : 4'd0;      // Active bank base
  wire logic [15:0] act_sp = user_sp ? usp_r : isp_r;      // RULE_12

  // Read value of any selector in the active bank, zero-extended
  function automatic logic [31:0] sel_read(input logic [3:0] sel,
                                           input logic [1:0] mode);
    logic [15:0] w;
    w = 16'h0000;
    sel_read = 32'h0;
    if (sel < 4'(BANK_REGS)) begin
      w = bank_r[act_base + sel];
      if (mode == MODE_PAIR && pair_hi(sel) != 4'hf) begin
        sel_read = {bank_r[act_base + pair_hi(sel)], w};  // RULE_04 RULE_06
      end else if (mode == MODE_LOW && sel < 4'd2) begin
        sel_read = {24'h0, w[7:0]};                       // RULE_03
      end else if (mode == MODE_HIGH && sel < 4'd2) begin
        sel_read = {24'h0, w[15:8]};                      // RULE_03
      end else begin
        sel_read = {16'h0, w};                            // RULE_02 RULE_05
      end
    end else begin
      unique case (sel)
        SEL_SB: sel_read = {16'h0, sb_r};                 // RULE_15
        SEL_USP: sel_read = {16'h0, usp_r};               // RULE_10
        SEL_ISP: sel_read = {16'h0, isp_r};               // RULE_10
        SEL_SP: sel_read = {16'h0, act_sp};               // RULE_11
        SEL_VECTOR_TABLE_BASE: sel_read = {12'h0, vector_table_base_r};             // RULE_09
        SEL_FLG: sel_read = {16'h0, flag_r};
        SEL_PC: sel_read = {12'h0, pc_r};                 // RULE_08
        default: sel_read = 32'h0;
      endcase
    end
  endfunction : sel_read

  //----------------------------------------------------------------------------
  // Bus write decode: the bus write becomes a word write on one selector
  //----------------------------------------------------------------------------
  wire logic ax_bank1 = aw_idx_r >= IDX_BANK1 && aw_idx_r < IDX_BANK1 + 5'd7;
  wire logic ax_bank0 = aw_idx_r < 5'd7;
  wire logic [3:0] ax_banked = ax_bank1 ? 4'(aw_idx_r - IDX_BANK1)
                                        : aw_idx_r[3:0];
  wire logic [3:0] ax_sel =
    (ax_bank0 || ax_bank1) ? ax_banked :
    aw_idx_r == IDX_VECTOR_TABLE_BASE ? SEL_VECTOR_TABLE_BASE : aw_idx_r == IDX_USP ? SEL_USP :
    aw_idx_r == IDX_ISP ? SEL_ISP : aw_idx_r == IDX_SB ? SEL_SB :
    aw_idx_r == IDX_FLG ? SEL_FLG : 4'hf;
  wire logic ax_bank = ax_bank1;
  wire logic [31:0] ax_old = (ax_bank0 || ax_bank1)
                             ? {16'h0, bank_r[(ax_bank1 ? 4'd7 : 4'd0)
                                              + ax_banked]}
                             : sel_read(ax_sel, MODE_WORD);
  // Core writes win; a pending bus write waits for a free cycle
  wire logic ax_go = aw_held_r && w_held_r && !bvalid_r && !wr_en_in;
  wire logic ax_ok = ax_sel != 4'hf;

  //----------------------------------------------------------------------------
  // Merged write port
  //----------------------------------------------------------------------------
  wire logic e_en = wr_en_in || (ax_go && ax_ok);
  wire logic [3:0] e_sel = wr_en_in ? wr_sel_in : ax_sel;
  wire logic [1:0] e_mode = wr_en_in ? wr_mode_in : MODE_WORD;
  wire logic e_bank = wr_en_in ? bank_sel : ax_bank;     // RULE_14
  wire logic [31:0] e_data = wr_en_in ? wr_data_in
                                      : strb_merge(ax_old, w_data_r, w_strb_r);
  wire logic e_byte = e_mode == MODE_LOW || e_mode == MODE_HIGH;
  // Byte modes exist only on the first two data registers
  wire logic e_lo_ok = !e_byte || e_sel < 4'd2;
  wire logic [3:0] e_hi = e_mode == MODE_PAIR ? pair_hi(e_sel) : 4'hf;
  wire logic e_unb = e_en && !e_byte;                    // Unbanked word or pair write
  wire logic e_sp_usp = e_sel == SEL_USP || (e_sel == SEL_SP && user_sp);
  wire logic e_sp_isp = e_sel == SEL_ISP || (e_sel == SEL_SP && !user_sp);

  //----------------------------------------------------------------------------
  // Banked registers: each entry updates only on its own hit
  //----------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < BANKED_TOTAL; i++) begin
      if (!rst_n_in) begin
        bank_r[i] <= RST_WORD;
      end else if (e_en && e_bank == (i >= BANK_REGS)) begin  // RULE_01
        if (e_hi == 4'(i % BANK_REGS)) begin
          bank_r[i] <= e_data[31:16];                         // RULE_17
        end else if (e_sel == 4'(i % BANK_REGS) && e_lo_ok) begin
          bank_r[i] <= merge16(bank_r[i], e_data, e_mode);    // RULE_17
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // Unbanked registers, the same whatever the bank select
  //----------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pc_r <= RST_PC;
      vector_table_base_r <= RST_VECTOR_TABLE_BASE;
      usp_r <= RST_WORD;
      isp_r <= RST_WORD;
      sb_r <= RST_WORD;
    end else begin
      if (pc_load_in) pc_r <= pc_data_in;                          // RULE_08
      if (e_unb && e_sel == SEL_VECTOR_TABLE_BASE) vector_table_base_r <= e_data[19:0];      // RULE_09
      if (e_unb && e_sp_usp) usp_r <= e_data[15:0];                // RULE_10
      if (e_unb && e_sp_isp) isp_r <= e_data[15:0];                // RULE_10
      if (e_unb && e_sel == SEL_SB) sb_r <= e_data[15:0];          // RULE_16
    end
  end

  // Flag word; acknowledge beats a same-cycle write of the stack flag
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      flag_r <= RST_FLG;
    end else begin
      flag_r <= (e_unb && e_sel == SEL_FLG) ? (e_data[15:0] & FLG_MASK)
                                            : flag_r;
      if (irq_ack_in) flag_r[FLG_STACK_BIT] <= 1'b0;  // RULE_13
    end
  end

  // Core read port, one cycle behind the select
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) rd_data_r <= 32'h0;
    else rd_data_r <= sel_read(rd_sel_in, rd_mode_in);
  end

  //----------------------------------------------------------------------------
  // AXI4-Lite slave
  //----------------------------------------------------------------------------
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [4:0] ar_idx = s_axi_araddr[6:2];
  wire logic ar_b1 = ar_idx >= IDX_BANK1 && ar_idx < IDX_BANK1 + 5'd7;
  wire logic ar_ok = ar_idx < 5'd7 || ar_b1 || (ar_idx >= IDX_PC
                                                && ar_idx <= IDX_FLG);
  wire logic [31:0] ar_data =
    ar_idx < 5'd7 ? {16'h0, bank_r[ar_idx[3:0]]} :
    ar_b1 ? {16'h0, bank_r[4'(ar_idx - IDX_BANK1) + 4'd7]} :
    ar_idx == IDX_PC ? {12'h0, pc_r} : ar_idx == IDX_VECTOR_TABLE_BASE ? {12'h0, vector_table_base_r} :
    ar_idx == IDX_USP ? {16'h0, usp_r} : ar_idx == IDX_ISP ? {16'h0, isp_r} :
    ar_idx == IDX_SB ? {16'h0, sb_r} : ar_idx == IDX_FLG ? {16'h0, flag_r} :
    32'h0;

  // Write channel: capture halves in either order, answer after commit
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 5'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[6:2];
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (ax_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= ax_ok ? RESP_OKAY : RESP_SLVERR;  // PC is read-only
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: one request at a time, data one cycle later
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= ar_data;
      rresp_r <= ar_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_data_out = rd_data_r;
  assign pc_out = pc_r;
  assign vector_table_base_out = vector_table_base_r;
  assign sp_out = act_sp;                                  // RULE_12
  assign fb_out = bank_r[act_base + SEL_FB];               // RULE_07
  assign sb_out = sb_r;                                    // RULE_15
  assign idx0_out = bank_r[act_base + SEL_IDX0];           // RULE_05
  assign idx1_out = bank_r[act_base + SEL_IDX1];
  assign flag_out = flag_r;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  wire logic cw = wr_en_in;
  AST_IRQ_CLEARS_STACK: assert property (irq_ack_in |=> !flag_out[7]) // RULE_13
    else $error("Stack select not cleared by acknowledge");
  AST_SP_SELECT: assert property (cw && wr_sel_in == SEL_SP // RULE_11
    && wr_mode_in == MODE_WORD && !flag_out[7] && !irq_ack_in
    |=> sp_out == $past(wr_data_in[15:0]) && flag_out[7] == 1'b0)
    else $error("Active stack pointer write lost");
  AST_USER_SP: assert property (cw && wr_sel_in == SEL_SP // RULE_12
    && wr_mode_in == MODE_WORD && flag_out[7]
    |=> usp_r == $past(wr_data_in[15:0]))
    else $error("Active stack write missed user pointer");
  AST_BYTE_KEEP: assert property (cw && wr_sel_in == SEL_ACC0 // RULE_03
    && wr_mode_in == MODE_LOW |=> bank_r[act_base][15:8]
    == $past(bank_r[act_base][15:8]))
    else $error("Low byte write disturbed high byte");
  AST_PAIR_HIGH: assert property (cw && wr_sel_in == SEL_ACC1 // RULE_04
    && wr_mode_in == MODE_PAIR
    |=> bank_r[act_base + SEL_ACC3] == $past(wr_data_in[31:16])
    && bank_r[act_base + SEL_ACC1] == $past(wr_data_in[15:0]))
    else $error("Pair write upper half wrong");
  AST_IDX_PAIR: assert property (cw && wr_sel_in == SEL_IDX0 // RULE_06
    && wr_mode_in == MODE_PAIR && !flag_out[4] && !irq_ack_in
    |=> idx1_out == $past(wr_data_in[31:16])
    && idx0_out == $past(wr_data_in[15:0]))
    else $error("Index pair write wrong");
  AST_BANK_ISOLATE: assert property (cw && !flag_out[4] // RULE_14
    |=> bank_r[7 + SEL_FB] == $past(bank_r[7 + SEL_FB]))
    else $error("Bank 1 changed by bank 0 write");
  AST_PC_LOAD: assert property (pc_load_in |=> pc_out // RULE_08
    == $past(pc_data_in))
    else $error("Program counter load lost");
  AST_FLAG_RSVD: assert property (flag_out[11:8] == 4'h0 // RULE_17
    && !flag_out[15])
    else $error("Reserved flag bits set");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("Write response dropped");
  COV_PAIR: cover property (cw && wr_mode_in == MODE_PAIR);
  COV_BANK1: cover property (flag_out[4] && cw);
  COV_IRQ: cover property (flag_out[7] ##1 irq_ack_in);
  COV_AXI_WR: cover property (s_axi_bvalid && s_axi_bready);

endmodule : crf_cpu_regs

// File: verification/crf_core_model.sv
// Core datapath model driving the register set's core port
// Assumes the bench clock; requests change right after rising edges
`timescale 1ns/1ps

module crf_core_model (
  input wire logic clock_in,          // Core clock
  input wire logic [31:0] rd_data_in, // Registered read data
  output logic wr_en_out,             // Write strobe
  output logic [3:0] wr_sel_out,      // Write target
  output logic [1:0] wr_mode_out,     // Write mode
  output logic [31:0] wr_data_out,    // Write data
  output logic [3:0] rd_sel_out,      // Read source
  output logic [1:0] rd_mode_out      // Read mode
);
  // Idle until the bench asks
  initial begin
    {wr_en_out, wr_sel_out, wr_mode_out, wr_data_out} = '0;
    {rd_sel_out, rd_mode_out} = '0;
  end

  // One write, strobe high for exactly one edge
  task automatic core_wr(input logic [3:0] s, input logic [1:0] m,
                         input logic [31:0] d);
    @(posedge clock_in);
    wr_en_out <= 1'b1;
    {wr_sel_out, wr_mode_out, wr_data_out} <= {s, m, d};
    @(posedge clock_in);
    wr_en_out <= 1'b0;
  endtask : core_wr

  // Read answers one edge later; sample after it settles
  task automatic core_rd(input logic [3:0] s, input logic [1:0] m,
                         output logic [31:0] d);
    @(posedge clock_in);
    {rd_sel_out, rd_mode_out} <= {s, m};
    @(posedge clock_in);
    #1 d = rd_data_in;
  endtask : core_rd
endmodule : crf_core_model

// File: verification/crf_cpu_regs_tb.sv
// Self-checking bench: core port table, then banks, stack and bus cases
// Assumes crf_pkg and crf_cpu_regs compiled first
`timescale 1ns/1ps

module crf_cpu_regs_tb;
  import crf_pkg::*;
  typedef struct packed {
    logic [3:0] s; logic [1:0] m; logic [31:0] d;
    logic [1:0] rm; logic [31:0] e;
  } crf_row_t;
  logic clk, rst_n, pcl, irq, awv, wv, brdy, arv, rrdy;
  logic [19:0] pcd;
  logic [6:0] awa, ara;
  logic [31:0] wd, rdat, cd, rd_q, rdata;
  logic [1:0] rsp, bresp, rresp;
  logic awr, wr, bv, arr, rv, we;
  logic [3:0] ws, rs;
  logic [1:0] wm, rm;
  logic [19:0] pc, vector_table_base;
  logic [15:0] sp, fb, sb, ix0, ix1, flag_word;
  int failures = 0;
  int total_checks = 0;
  crf_row_t rows [12] = '{
    '{SEL_ACC0, MODE_WORD, 32'h1234, MODE_WORD, 32'h1234},
    '{SEL_ACC0, MODE_LOW, 32'h00ab, MODE_WORD, 32'h12ab},
    '{SEL_ACC0, MODE_HIGH, 32'h00cd, MODE_HIGH, 32'h00cd},
    '{SEL_ACC0, MODE_PAIR, 32'h5678_9abc, MODE_PAIR, 32'h5678_9abc},
    '{SEL_ACC1, MODE_PAIR, 32'h1111_2222, MODE_PAIR, 32'h1111_2222},
    '{SEL_IDX0, MODE_PAIR, 32'haaaa_bbbb, MODE_PAIR, 32'haaaa_bbbb},
    '{SEL_FB, MODE_WORD, 32'h4321, MODE_WORD, 32'h4321},
    '{SEL_VECTOR_TABLE_BASE, MODE_WORD, 32'hfff1_2345, MODE_WORD, 32'h1_2345},
    '{SEL_SB, MODE_WORD, 32'h5a5a, MODE_WORD, 32'h5a5a},
    '{SEL_USP, MODE_WORD, 32'h1111, MODE_WORD, 32'h1111},
    '{SEL_ISP, MODE_WORD, 32'h2222, MODE_WORD, 32'h2222},
    '{SEL_FLG, MODE_WORD, 32'hffff, MODE_WORD, 32'h70ff}};

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  crf_core_model i_core (.clock_in(clk), .rd_data_in(rdat), .wr_en_out(we),
    .wr_sel_out(ws), .wr_mode_out(wm), .wr_data_out(cd), .rd_sel_out(rs),
    .rd_mode_out(rm));
  crf_cpu_regs i_dut (.clock_in(clk), .rst_n_in(rst_n), .wr_en_in(we),
    .wr_sel_in(ws), .wr_mode_in(wm), .wr_data_in(cd), .rd_sel_in(rs),
    .rd_mode_in(rm), .rd_data_out(rdat), .pc_load_in(pcl),
    .pc_data_in(pcd), .irq_ack_in(irq), .pc_out(pc), .vector_table_base_out(vector_table_base),
    .sp_out(sp), .fb_out(fb), .sb_out(sb), .idx0_out(ix0),
    .idx1_out(ix1), .flag_out(flag_word), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy));

  // Value and response compares
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    chk(n, {30'h0, e}, {30'h0, g});
  endtask : chk_resp

  // Verdict; a spent wait lands here too
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Bus write; each channel drops valid once taken, bounded wait
  task automatic axi_wr(input logic [6:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic got;
    got = 1'b0;
    @(posedge clk);
    {awv, wv, brdy, awa, wd} <= {3'b111, a, d};
    // Readies and bvalid read here are what this edge sampled
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) begin
        r = bresp;
        got = 1'b1;
      end
    end
    brdy <= 1'b0;
    if (!got) begin failures++; final_report(); end
  endtask : axi_wr

  // Bus read, bounded wait on rvalid
  task automatic axi_rd(input logic [6:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic got;
    got = 1'b0;
    @(posedge clk);
    {arv, rrdy, ara} <= {2'b11, a};
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        {d, r} = {rdata, rresp};
        got = 1'b1;
      end
    end
    rrdy <= 1'b0;
    if (!got) begin failures++; final_report(); end
  endtask : axi_rd

  // Main sequence
  initial begin
    {rst_n, pcl, irq, awv, wv, brdy, arv, rrdy} = '0;
    {pcd, awa, ara, wd} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("flag", 32'h0, flag_word);
    chk("bvalid", 32'h0, {31'h0, bv});
    foreach (rows[i]) begin
      i_core.core_wr(rows[i].s, rows[i].m, rows[i].d);
      i_core.core_rd(rows[i].s, rows[i].rm, rd_q);
      chk("row", rows[i].e, rd_q);
    end
    chk("sp", 32'h1111, sp);
    i_core.core_wr(SEL_SP, MODE_WORD, 32'h4444);
    #1 chk("sp user", 32'h4444, sp);
    chk("fb", 32'h0, fb);
    chk("vector_table_base", 32'h1_2345, vector_table_base);
    chk("sb", 32'h5a5a, sb);
    @(posedge clk);
    {irq, pcl, pcd} <= {2'b11, 20'habcde};
    @(posedge clk);
    {irq, pcl} <= 2'b00;
    #1 chk("flag", 32'h707f, flag_word);
    chk("sp", 32'h2222, sp);
    i_core.core_wr(SEL_SP, MODE_WORD, 32'h3333);
    #1 chk("sp irq", 32'h3333, sp);
    i_core.core_wr(SEL_PC, MODE_WORD, 32'h1);
    #1 chk("pc", 32'habcde, pc);
    axi_rd(7'h00, rd_q, rsp);
    chk("bank0 acc0", 32'h9abc, rd_q);
    chk_resp("rd resp", RESP_OKAY, rsp);
    axi_wr(7'h20, 32'hbeef, rsp);
    chk_resp("wr resp", RESP_OKAY, rsp);
    i_core.core_rd(SEL_ACC0, MODE_WORD, rd_q);
    chk("bank1 acc0", 32'hbeef, rd_q);
    axi_wr(7'h40, 32'h1, rsp);
    chk_resp("pc resp", RESP_SLVERR, rsp);
    axi_rd(7'h1c, rd_q, rsp);
    chk_resp("unmapped", RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd_q);
    i_core.core_wr(SEL_IDX0, MODE_PAIR, 32'h0246_1357);
    #1 chk("idx0", 32'h1357, ix0);
    chk("idx1", 32'h0246, ix1);
    final_report();
  end
endmodule : crf_cpu_regs_tb
